// ### ssp_pkg.sv
// Purpose: Shared constants and types for the synchronous serial port
// Assumes: Word-addressed 16-bit register port, at most 8 live bits per register
// Notes: Field positions are bit indexes within the low byte
package ssp_pkg;
  // Register frame, word addresses
  localparam logic [15:0] ADDR_CONFIG = 16'h7040;
  localparam logic [15:0] ADDR_CONTROL = 16'h7041;
  localparam logic [15:0] ADDR_STATUS = 16'h7042;
  localparam logic [15:0] ADDR_RATE = 16'h7044;
  localparam logic [15:0] ADDR_RX_EMU = 16'h7046;
  localparam logic [15:0] ADDR_RX_BUF = 16'h7047;
  localparam logic [15:0] ADDR_TX_BUF = 16'h7048;
  localparam logic [15:0] ADDR_SHIFT = 16'h7049;
  localparam logic [15:0] ADDR_FIFO_TX = 16'h704a;
  localparam logic [15:0] ADDR_FIFO_RX = 16'h704b;
  localparam logic [15:0] ADDR_FIFO_DLY = 16'h704c;
  localparam logic [15:0] ADDR_PRIORITY = 16'h704f;
  // Field positions
  localparam int CFG_RUN = 7;
  localparam int CFG_POL = 6;
  localparam int CTL_OVR_IE = 4;
  localparam int CTL_PHASE = 3;
  localparam int CTL_MASTER = 2;
  localparam int CTL_TALK = 1;
  localparam int CTL_IE = 0;
  localparam int STS_OVR = 7;
  localparam int FF_EN = 6;
  localparam int FF_RUN = 5;
  // Reset values
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [7:0] CTL_RST = 8'h00;
  localparam logic [7:0] FF_RST = 8'h20;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  // Depths and rate limits
  localparam logic [4:0] FIFO_CAP = 5'h10;
  localparam logic [4:0] PLAIN_CAP = 5'h01;
  localparam logic [4:0] WORD_BITS = 5'h10;
  localparam logic [6:0] MIN_DIV = 7'h03;
  localparam logic [7:0] SLOW_PERIOD = 8'h04;
  typedef enum logic [1:0] {
    SSP_IDLE = 2'b00,
    SSP_XFER = 2'b01,
    SSP_GAP = 2'b10
  } ssp_state_t;
endpackage

// ### ssp_fifo.sv
// Purpose: Sixteen-word FIFO store with registered read data
// Assumes: Read data shows the head one cycle after pointers settle
// Notes: cap limits depth so the same store serves unbuffered mode
module ssp_fifo (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clr,
  input wire logic push,
  input wire logic pop,
  input wire logic [4:0] cap,
  input wire logic [15:0] wdata,
  output logic [15:0] rdata,
  output logic [4:0] count
);
  logic [15:0] mem [0:15];
  logic [3:0] wp;
  logic [3:0] rp;
  logic do_push;
  logic do_pop;

  // Full and empty refuse silently; caller checks count
  assign do_push = push && (count < cap);
  assign do_pop = pop && (count != 5'h00);

  // Storage write
  always_ff @(posedge clk) begin
    if (do_push) begin
      mem[wp] <= wdata;
    end
  end

  // Registered head read
  always_ff @(posedge clk) begin
    rdata <= mem[rp];
  end

  // Pointers and fill level
  always_ff @(posedge clk) begin
    if (sys_rst || clr) begin
      wp <= 4'h0;
      rp <= 4'h0;
      count <= 5'h00;
    end else begin
      if (do_push) wp <= wp + 4'h1;
      if (do_pop) rp <= rp + 4'h1;
      count <= count + {4'h0, do_push} - {4'h0, do_pop};
    end
  end
endmodule // ssp_fifo

// ### ssp_port.sv
// Purpose: Synchronous four-wire serial port, master or slave
// Assumes: clk is also the peripheral bit-rate clock; pins are synchronous
// Notes: Notes on behaviour list follows
module ssp_port (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [15:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  input wire logic serial_clock_line_i,
  output logic serial_clock_line_o,
  output logic serial_clock_line_oe,
  input wire logic slave_out_master_in_line_i,
  output logic slave_out_master_in_line_o,
  output logic slave_out_master_in_line_oe,
  input wire logic slave_in_master_out_line_i,
  output logic slave_in_master_out_line_o,
  output logic slave_in_master_out_line_oe,
  input wire logic slave_transmit_enable_line_n_i,
  output logic slave_transmit_enable_line_n_o,
  output logic slave_transmit_enable_line_n_oe,
  output logic rx_int,
  output logic tx_int
);
  logic [7:0] cfg;
  logic [7:0] ctl;
  logic [6:0] rate;
  logic [7:0] dly;
  logic [7:0] pri;
  logic [7:0] fftx;
  logic [7:0] ffrx;
  logic ovr;
  ssp_pkg::ssp_state_t state;
  logic [7:0] div;
  logic [7:0] gap;
  logic [5:0] ecnt;
  logic loaded;
  logic tx_rdy;
  logic sclk_q;
  logic mo;
  logic [15:0] tx_sh;
  logic [15:0] rx_sh;
  logic [15:0] q0;
  logic [15:0] q1;
  logic [1:0] sk_cnt;
  logic [7:0] next_rbyte;
  logic [15:0] tx_word;
  logic [15:0] rx_head;
  logic [4:0] tx_count;
  logic [4:0] rx_count;

  // Peripheral bit period in clk cycles
  function automatic logic [7:0] bit_period(input logic [6:0] d);
    if (d < ssp_pkg::MIN_DIV) begin
      return ssp_pkg::SLOW_PERIOD;
    end
    return {1'b0, d} + 8'h01;
  endfunction

  logic run, pol, phase, master, talk, fifo_en;
  logic [4:0] cap, len, sh_amt;
  logic [5:0] edges_word;
  logic [7:0] period, half;
  logic wr_tx, rd_rx, edge_m, edge_s, edge_any, wrap, cur_lvl;
  logic lead, trail, sample_ev, drive_ev, load_ev, pop_tx, word_done;
  logic in_bit, acc, push_rx;
  logic [1:0] eff;
  logic [15:0] tx_just, tx_load, mask, rx_word;

  // Control fields
  assign run = cfg[ssp_pkg::CFG_RUN];
  assign pol = cfg[ssp_pkg::CFG_POL];
  assign phase = ctl[ssp_pkg::CTL_PHASE];
  assign master = ctl[ssp_pkg::CTL_MASTER];
  assign talk = ctl[ssp_pkg::CTL_TALK];
  assign fifo_en = fftx[ssp_pkg::FF_EN];
  // Unbuffered mode reuses the FIFO at depth one
  assign cap = fifo_en ? ssp_pkg::FIFO_CAP : ssp_pkg::PLAIN_CAP;
  assign len = {1'b0, cfg[3:0]} + 5'h01;
  assign edges_word = {len, 1'b0};
  assign sh_amt = ssp_pkg::WORD_BITS - len;

  // Register strobes, full-word accesses only
  assign wr_tx = reg_wr && (reg_addr == ssp_pkg::ADDR_TX_BUF ||
                 reg_addr == ssp_pkg::ADDR_SHIFT);
  assign rd_rx = reg_rd && reg_addr == ssp_pkg::ADDR_RX_BUF;

  // Master bit clock divider
  assign period = bit_period(rate);
  assign half = period >> 1;
  assign wrap = div == period - 8'h01;
  assign edge_m = master && state == ssp_pkg::SSP_XFER &&
                  (wrap || div == half - 8'h01);
  // Deselected slave sees no clock edges
  assign edge_s = !master && !slave_transmit_enable_line_n_i &&
                  serial_clock_line_i != sclk_q;
  assign edge_any = run && (master ? edge_m : edge_s);
  assign cur_lvl = master ? serial_clock_line_o : sclk_q;
  assign lead = edge_any && cur_lvl == pol;
  assign trail = edge_any && cur_lvl != pol;
  // Phase delay samples on the first edge, else on the second
  assign sample_ev = phase ? lead : trail;
  assign drive_ev = phase ? trail : lead;

  // Word start: master when data settled, slave when selected
  assign load_ev = run && (master ?
                   (state == ssp_pkg::SSP_IDLE && tx_rdy) :
                   (!slave_transmit_enable_line_n_i && !loaded));
  assign pop_tx = load_ev && tx_rdy;
  assign word_done = edge_any && ecnt == edges_word - 6'h01 &&
                     (master ? state == ssp_pkg::SSP_XFER : loaded);
  assign tx_just = tx_word << sh_amt;
  assign tx_load = pop_tx ? tx_just : 16'h0000;
  assign in_bit = master ? slave_out_master_in_line_i :
                  slave_in_master_out_line_i;
  assign mask = 16'hffff >> sh_amt;
  assign rx_word = (phase ? rx_sh : {rx_sh[14:0], in_bit}) & mask;

  // Two-entry buffer between shifter and receive FIFO
  assign acc = word_done && sk_cnt != 2'h2;
  assign push_rx = sk_cnt != 2'h0 && rx_count < cap;
  assign eff = sk_cnt - {1'b0, push_rx};

  ssp_fifo u_tx_fifo (
    .clk(clk),
    .sys_rst(sys_rst),
    .clr(!run || !fftx[ssp_pkg::FF_RUN]),
    .push(wr_tx),
    .pop(pop_tx),
    .cap(cap),
    .wdata({ssp_pkg::BYTE_ZERO, reg_wdata[7:0]}),
    .rdata(tx_word),
    .count(tx_count)
  );

  ssp_fifo u_rx_fifo (
    .clk(clk),
    .sys_rst(sys_rst),
    .clr(!run || !ffrx[ssp_pkg::FF_RUN]),
    .push(push_rx),
    .pop(rd_rx),
    .cap(cap),
    .wdata(q0),
    .rdata(rx_head),
    .count(rx_count)
  );

  // Control register writes; upper byte is dropped
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cfg <= ssp_pkg::CFG_RST;
      ctl <= ssp_pkg::CTL_RST;
      rate <= 7'h00;
      dly <= ssp_pkg::BYTE_ZERO;
      pri <= ssp_pkg::BYTE_ZERO;
      fftx <= ssp_pkg::FF_RST;
      ffrx <= ssp_pkg::FF_RST;
    end else if (reg_wr) begin
      case (reg_addr)
        ssp_pkg::ADDR_CONFIG: cfg <= reg_wdata[7:0];
        ssp_pkg::ADDR_CONTROL: ctl <= reg_wdata[7:0];
        ssp_pkg::ADDR_RATE: rate <= reg_wdata[6:0];
        ssp_pkg::ADDR_FIFO_DLY: dly <= reg_wdata[7:0];
        ssp_pkg::ADDR_PRIORITY: pri <= reg_wdata[7:0];
        ssp_pkg::ADDR_FIFO_TX: fftx <= reg_wdata[7:0];
        ssp_pkg::ADDR_FIFO_RX: ffrx <= reg_wdata[7:0];
        default: ;
      endcase
    end
  end

  // Overrun flag: a lost word wins over a same-cycle clear
  always_ff @(posedge clk) begin
    if (sys_rst || !run) begin
      ovr <= 1'b0;
    end else if (word_done && !acc) begin
      ovr <= 1'b1;
    end else if (reg_wr && reg_addr == ssp_pkg::ADDR_STATUS &&
                 reg_wdata[ssp_pkg::STS_OVR]) begin
      ovr <= 1'b0;
    end
  end

  // Read data selection
  always_comb begin
    case (reg_addr)
      ssp_pkg::ADDR_CONFIG: next_rbyte = cfg;
      ssp_pkg::ADDR_CONTROL: next_rbyte = ctl;
      ssp_pkg::ADDR_STATUS:
        next_rbyte = {ovr, rx_count != 5'h00, tx_count >= cap,
                      5'h00};
      ssp_pkg::ADDR_RATE: next_rbyte = {1'b0, rate};
      ssp_pkg::ADDR_RX_EMU: next_rbyte = rx_head[7:0];
      ssp_pkg::ADDR_RX_BUF: next_rbyte = rx_head[7:0];
      ssp_pkg::ADDR_TX_BUF: next_rbyte = tx_word[7:0];
      ssp_pkg::ADDR_SHIFT: next_rbyte = rx_sh[7:0];
      ssp_pkg::ADDR_FIFO_TX: next_rbyte = {fftx[7:5], tx_count};
      ssp_pkg::ADDR_FIFO_RX: next_rbyte = {ffrx[7:5], rx_count};
      ssp_pkg::ADDR_FIFO_DLY: next_rbyte = dly;
      ssp_pkg::ADDR_PRIORITY: next_rbyte = pri;
      default: next_rbyte = ssp_pkg::BYTE_ZERO;
    endcase
  end

  // Read port; unmapped words read zero
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      reg_rdata <= {ssp_pkg::BYTE_ZERO, next_rbyte};
    end
  end

  // Transmit data is valid one cycle after any pointer move
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tx_rdy <= 1'b0;
    end else begin
      tx_rdy <= tx_count != 5'h00 && !pop_tx && !wr_tx;
    end
  end

  // Master sequencing with inter-word wait
  always_ff @(posedge clk) begin
    if (sys_rst || !run) begin
      state <= ssp_pkg::SSP_IDLE;
      gap <= ssp_pkg::BYTE_ZERO;
    end else begin
      case (state)
        ssp_pkg::SSP_IDLE: begin
          if (master && load_ev) state <= ssp_pkg::SSP_XFER;
        end
        ssp_pkg::SSP_XFER: begin
          if (word_done) begin
            state <= ssp_pkg::SSP_GAP;
            gap <= fifo_en ? dly : ssp_pkg::BYTE_ZERO;
          end
        end
        ssp_pkg::SSP_GAP: begin
          if (gap == ssp_pkg::BYTE_ZERO) begin
            state <= ssp_pkg::SSP_IDLE;
          end else if (wrap) begin
            gap <= gap - 8'h01;
          end
        end
        default: state <= ssp_pkg::SSP_IDLE;
      endcase
    end
  end

  // Divider runs only while a word or its wait is in progress
  always_ff @(posedge clk) begin
    if (sys_rst || state == ssp_pkg::SSP_IDLE) begin
      div <= ssp_pkg::BYTE_ZERO;
    end else begin
      div <= wrap ? ssp_pkg::BYTE_ZERO : div + 8'h01;
    end
  end

  // Edge count and slave word framing
  always_ff @(posedge clk) begin
    if (sys_rst || !run || master || slave_transmit_enable_line_n_i) begin
      loaded <= 1'b0;
    end else if (load_ev) begin
      loaded <= 1'b1;
    end else if (word_done) begin
      loaded <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst || !run || load_ev || word_done ||
        (!master && slave_transmit_enable_line_n_i)) begin
      ecnt <= 6'h00;
    end else if (edge_any) begin
      ecnt <= ecnt + 6'h01;
    end
  end

  // Previous level of the slave clock for edge detection
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sclk_q <= 1'b0;
    end else begin
      sclk_q <= serial_clock_line_i;
    end
  end

  // Transmit shifter, MSB first; delayed phase presets the first bit
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tx_sh <= 16'h0000;
      mo <= 1'b0;
    end else if (load_ev) begin
      if (phase) mo <= tx_load[15];
      tx_sh <= phase ? tx_load << 1 : tx_load;
    end else if (drive_ev) begin
      mo <= tx_sh[15];
      tx_sh <= tx_sh << 1;
    end
  end

  // Receive shifter runs whether or not transmit is enabled
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rx_sh <= 16'h0000;
    end else if (sample_ev) begin
      rx_sh <= {rx_sh[14:0], in_bit};
    end
  end

  // Buffer absorbs a word while the receive FIFO is full
  always_ff @(posedge clk) begin
    if (sys_rst || !run) begin
      sk_cnt <= 2'h0;
      q0 <= 16'h0000;
      q1 <= 16'h0000;
    end else begin
      if (push_rx) q0 <= q1;
      if (acc && eff == 2'h0) q0 <= rx_word;
      if (acc && eff != 2'h0) q1 <= rx_word;
      sk_cnt <= eff + {1'b0, acc};
    end
  end

  // Pin drivers; transmit off releases only the data output
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      serial_clock_line_o <= 1'b0;
      serial_clock_line_oe <= 1'b0;
      slave_out_master_in_line_oe <= 1'b0;
      slave_in_master_out_line_oe <= 1'b0;
      slave_transmit_enable_line_n_o <= 1'b1;
      slave_transmit_enable_line_n_oe <= 1'b0;
    end else begin
      if (state != ssp_pkg::SSP_XFER) begin
        serial_clock_line_o <= pol;
      end else if (edge_m) begin
        serial_clock_line_o <= !serial_clock_line_o;
      end
      serial_clock_line_oe <= run && master;
      slave_in_master_out_line_oe <= run && master && talk;
      slave_out_master_in_line_oe <= run && !master && talk &&
        !slave_transmit_enable_line_n_i;
      slave_transmit_enable_line_n_o <= state != ssp_pkg::SSP_XFER;
      slave_transmit_enable_line_n_oe <= run && master;
    end
  end

  assign slave_in_master_out_line_o = mo;
  assign slave_out_master_in_line_o = mo;

  // Service requests for interrupt-driven software
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rx_int <= 1'b0;
      tx_int <= 1'b0;
    end else begin
      rx_int <= (ctl[ssp_pkg::CTL_IE] && rx_count != 5'h00) ||
                (ctl[ssp_pkg::CTL_OVR_IE] && ovr);
      tx_int <= ctl[ssp_pkg::CTL_IE] && run && tx_count == 5'h00;
    end
  end
endmodule // ssp_port

// ### ssp_chk.sv
// Purpose: Port-level checks for the serial port
// Assumes: Shadows of config, control and rate follow register writes
// Notes: Half-period check runs only for even bit periods
module ssp_chk (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [15:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic serial_clock_line_o,
  input wire logic serial_clock_line_oe,
  input wire logic slave_out_master_in_line_oe,
  input wire logic slave_in_master_out_line_oe,
  input wire logic slave_transmit_enable_line_n_i,
  input wire logic slave_transmit_enable_line_n_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic [7:0] cfg, ctl, rate, cnt;
  logic prev_sck, seen;
  wire [7:0] wb = reg_wdata[7:0];
  wire sck_moved = serial_clock_line_o != prev_sck;
  wire [7:0] per = (rate[6:0] < ssp_pkg::MIN_DIV) ? ssp_pkg::SLOW_PERIOD
    : {1'b0, rate[6:0]} + 8'h01;
  // Low-byte shadows, so upper write data can never reach them
  always_ff @(posedge clk)
    if (sys_rst) cfg <= ssp_pkg::CFG_RST;
    else if (reg_wr && reg_addr == ssp_pkg::ADDR_CONFIG) cfg <= wb;
  always_ff @(posedge clk)
    if (sys_rst) ctl <= ssp_pkg::CTL_RST;
    else if (reg_wr && reg_addr == ssp_pkg::ADDR_CONTROL) ctl <= wb;
  always_ff @(posedge clk)
    if (sys_rst) rate <= 8'h00;
    else if (reg_wr && reg_addr == ssp_pkg::ADDR_RATE) rate <= wb;
  // Cycles since the clock last moved; first edge of a word is not timed
  always_ff @(posedge clk) begin
    prev_sck <= serial_clock_line_o;
    cnt <= sck_moved ? 8'h01 : cnt + 8'h01;
    seen <= !slave_transmit_enable_line_n_o && (seen || sck_moved);
  end
  property p_upper_zero; reg_rdata[15:8] == 8'h00; endproperty
  a_upper_zero: assert property (p_upper_zero)
    else $error("upper read byte not zero");
  property p_unmapped; reg_rd && reg_addr == 16'h7043 |=>
    reg_rdata == 16'h0000; endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  property p_cfg_back; reg_rd && reg_addr == ssp_pkg::ADDR_CONFIG |=>
    reg_rdata == {8'h00, cfg}; endproperty
  a_cfg_back: assert property (p_cfg_back)
    else $error("config read back differs from low-byte writes");
  property p_half; sck_moved && seen && !per[0] |-> cnt == (per >> 1);
  endproperty
  a_half: assert property (p_half)
    else $error("serial clock half period wrong");
  property p_idle; serial_clock_line_oe && slave_transmit_enable_line_n_o
    && $past(slave_transmit_enable_line_n_o) && $stable(cfg)
    |-> serial_clock_line_o == cfg[ssp_pkg::CFG_POL]; endproperty
  a_idle: assert property (p_idle)
    else $error("serial clock not at idle level between words");
  // Idle level follows a polarity write one cycle late, so skip two cycles
  property p_in_word; serial_clock_line_oe && $past(serial_clock_line_oe)
    && $changed(serial_clock_line_o) && $past(cfg) == $past(cfg, 2)
    |-> !$past(slave_transmit_enable_line_n_o); endproperty
  a_in_word: assert property (p_in_word)
    else $error("serial clock moved outside a selected word");
  property p_release; slave_transmit_enable_line_n_i [*3]
    |-> !slave_out_master_in_line_oe; endproperty
  a_release: assert property (p_release)
    else $error("deselected slave still drives its output");
  property p_talk; serial_clock_line_oe && $past(serial_clock_line_oe)
    && $stable(ctl) |-> slave_in_master_out_line_oe == ctl[ssp_pkg::CTL_TALK];
  endproperty
  a_talk: assert property (p_talk)
    else $error("master data output enable does not follow talk bit");
endmodule // ssp_chk

bind ssp_port ssp_chk u_chk (.clk, .sys_rst, .reg_addr, .reg_wr, .reg_rd,
  .reg_wdata, .reg_rdata, .serial_clock_line_o, .serial_clock_line_oe,
  .slave_out_master_in_line_oe, .slave_in_master_out_line_oe,
  .slave_transmit_enable_line_n_i, .slave_transmit_enable_line_n_o);

// ### ssp_peer.sv
// Purpose: Behavioural serial slave facing the port in master mode
// Assumes: Eight-bit words, most significant bit first
// Notes: Released data line shows the inverse of its last bit
module ssp_peer (
  input wire logic sck,
  input wire logic mosi,
  input wire logic sel_n,
  input wire logic pol,
  input wire logic pha,
  input wire logic [7:0] tx_word,
  output logic miso,
  output logic [7:0] rx_word
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] txs;
  wire lead = sck ^ pol;
  initial miso = 1'b0;
  // Selection loads the word; delayed phase presets its first bit
  always @(negedge sel_n) begin
    txs = tx_word;
    if (pha) begin
      miso = txs[7];
      txs = txs << 1;
    end
  end
  // Drive on one clock edge, sample on the other, as phase selects
  always @(lead)
    if (!sel_n) begin
      if (lead ^ pha) begin
        miso = txs[7];
        txs = txs << 1;
      end else
        rx_word = {rx_word[6:0], mosi};
    end
  // No pull on this line, so a stale level must not look valid
  always @(posedge sel_n) miso = ~miso;
endmodule // ssp_peer

// ### synchronous_serial_port_bench.sv
// Purpose: Self-checking bench for the serial port
// Assumes: Peer is an eight-bit slave; inputs change on falling clk
// Notes: Rows cover the four clocking schemes and the slow-rate floor
module synchronous_serial_port_bench;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic pol;
    logic pha;
    logic [7:0] rate;
    logic [7:0] tx;
    logic [7:0] peer;
  } ssp_row_t;
  logic clk, sys_rst, reg_wr, reg_rd, sel_n_in, pol, pha, miso;
  logic sck_o, sck_oe, somi_o, somi_oe, simo_o, simo_oe, ste_o, ste_oe;
  logic rx_int, tx_int;
  logic [15:0] reg_addr, reg_wdata, reg_rdata, rd_val;
  logic [7:0] peer_tx, peer_rx;
  int fails, num_checks;
  ssp_row_t rows [4] = '{'{1'b0, 1'b0, 8'h03, 8'ha5, 8'h3c},
    '{1'b1, 1'b0, 8'h07, 8'h81, 8'hc3}, '{1'b0, 1'b1, 8'h00, 8'h5a, 8'h96},
    '{1'b1, 1'b1, 8'h09, 8'h01, 8'h7e}};
  // Released lines: clock rests at polarity, data shows inverse
  wire sck = sck_oe ? sck_o : pol;
  wire mosi = simo_oe ? simo_o : ~simo_o;
  wire peer_sel_n = ste_oe ? ste_o : 1'b1;
  ssp_port dut (.clk, .sys_rst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
    .reg_rdata, .serial_clock_line_i(sck), .serial_clock_line_o(sck_o),
    .serial_clock_line_oe(sck_oe), .slave_out_master_in_line_i(miso),
    .slave_out_master_in_line_o(somi_o),
    .slave_out_master_in_line_oe(somi_oe),
    .slave_in_master_out_line_i(mosi), .slave_in_master_out_line_o(simo_o),
    .slave_in_master_out_line_oe(simo_oe),
    .slave_transmit_enable_line_n_i(sel_n_in),
    .slave_transmit_enable_line_n_o(ste_o),
    .slave_transmit_enable_line_n_oe(ste_oe), .rx_int, .tx_int);
  ssp_peer peer (.sck, .mosi, .sel_n(peer_sel_n), .pol, .pha,
    .tx_word(peer_tx), .miso, .rx_word(peer_rx));
  // 20 MHz system clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [15:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Whole 16-bit accesses only; an idle cycle separates strobes
  task automatic wr(input logic [15:0] a, d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [15:0] a);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    @(negedge clk);
    rd_val = reg_rdata;
  endtask
  // Poll status until a received word is waiting, with a bound
  task automatic wait_rx;
    rd_val = 16'h0000;
    for (int i = 0; i < 300 && rd_val[6] !== 1'b1; i++)
      rd(ssp_pkg::ADDR_STATUS);
    chk("rx ready", rd_val[6], 1'b1);
  endtask
  task automatic end_sim;
    if (fails == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    {reg_wr, reg_rd, pol, pha} = 4'h0;
    sys_rst = 1'b1;
    sel_n_in = 1'b1;
    reg_addr = 16'h0000;
    reg_wdata = 16'h0000;
    peer_tx = 8'h00;
    fails = 0;
    num_checks = 0;
    repeat (6) @(negedge clk);
    sys_rst = 1'b0;
    rd(ssp_pkg::ADDR_CONFIG);
    chk("config reset", rd_val, {8'h00, ssp_pkg::CFG_RST});
    rd(ssp_pkg::ADDR_FIFO_TX);
    chk("fifo reset", rd_val, {8'h00, ssp_pkg::FF_RST});
    rd(16'h7043);
    chk("unmapped", rd_val, 16'h0000);
    foreach (rows[i]) begin
      pol = rows[i].pol;
      pha = rows[i].pha;
      peer_tx = rows[i].peer;
      wr(ssp_pkg::ADDR_CONTROL, {8'hff, 4'h0, pha, 3'b111});
      wr(ssp_pkg::ADDR_RATE, {8'h5a, rows[i].rate});
      wr(ssp_pkg::ADDR_CONFIG, {8'hc3, 1'b1, pol, 6'h07});
      rd(ssp_pkg::ADDR_CONFIG);
      chk("config", rd_val, {8'h00, 1'b1, pol, 6'h07});
      wr(ssp_pkg::ADDR_TX_BUF, {8'hff, rows[i].tx});
      wait_rx();
      chk("tx int", tx_int, 1'b1);
      chk("rx int", rx_int, 1'b1);
      rd(ssp_pkg::ADDR_RX_BUF);
      chk("rx", rd_val, {8'h00, rows[i].peer});
      chk("peer", peer_rx, rows[i].tx);
      chk("rx int clear", rx_int, 1'b0);
    end
    // One-bit word with transmit off: reception still runs
    peer_tx = 8'h80;
    pha = 1'b0;
    wr(ssp_pkg::ADDR_CONTROL, 16'h0004);
    wr(ssp_pkg::ADDR_CONFIG, {8'h00, 1'b1, pol, 6'h00});
    wr(ssp_pkg::ADDR_TX_BUF, 16'h00ff);
    wait_rx();
    chk("talk off", simo_oe, 1'b0);
    rd(ssp_pkg::ADDR_RX_BUF);
    chk("one bit", rd_val, 16'h0001);
    // Fill the transmit FIFO past its depth; a deselected slave never pops
    // and a stopped port would hold the FIFO cleared
    wr(ssp_pkg::ADDR_CONTROL, 16'h0000);
    wr(ssp_pkg::ADDR_CONFIG, {8'h00, 1'b1, pol, 6'h07});
    wr(ssp_pkg::ADDR_FIFO_TX, 16'h0060);
    repeat (17) wr(ssp_pkg::ADDR_TX_BUF, 16'h0011);
    rd(ssp_pkg::ADDR_FIFO_TX);
    chk("fifo full", rd_val, 16'h0070);
    rd(ssp_pkg::ADDR_STATUS);
    chk("tx full", rd_val[5], 1'b1);
    wr(ssp_pkg::ADDR_FIFO_TX, 16'h0040);
    wr(ssp_pkg::ADDR_FIFO_TX, 16'h0060);
    rd(ssp_pkg::ADDR_FIFO_TX);
    chk("fifo clear", rd_val, 16'h0060);
    // Slave role: output driven only while selected
    wr(ssp_pkg::ADDR_CONTROL, 16'h0002);
    wr(ssp_pkg::ADDR_CONFIG, {8'h00, 1'b1, pol, 6'h07});
    repeat (3) @(negedge clk);
    chk("somi idle", somi_oe, 1'b0);
    sel_n_in = 1'b0;
    repeat (3) @(negedge clk);
    chk("somi drive", somi_oe, 1'b1);
    sel_n_in = 1'b1;
    repeat (3) @(negedge clk);
    chk("somi release", somi_oe, 1'b0);
    // Mid-run reset returns pins and registers to their idle values
    @(negedge clk);
    sys_rst = 1'b1;
    repeat (2) @(negedge clk);
    sys_rst = 1'b0;
    chk("pins after reset", {sck_o, ste_o, sck_oe, somi_oe, simo_oe, ste_oe,
      rx_int, tx_int}, 8'h40);
    rd(ssp_pkg::ADDR_FIFO_TX);
    chk("fifo after reset", rd_val, {8'h00, ssp_pkg::FF_RST});
    rd(ssp_pkg::ADDR_CONFIG);
    chk("config after reset", rd_val, {8'h00, ssp_pkg::CFG_RST});
    end_sim();
  end
  // Hang guard: the sequence needs a few hundred cycles
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    end_sim();
  end
endmodule // synchronous_serial_port_bench
